// ==== sspc_core.sv ====
`timescale 1ns/1ps
`include "sspc_params.svh"
`default_nettype none

// generic fifo, depth a power of two
module sspc_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = $clog2(D)
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        count
);
  logic [W-1:0] mem_q [D];  // storage
  logic [AW:0]  wr_q;       // write pointer, wrap bit on top
  logic [AW:0]  rd_q;       // read pointer

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("sspc_fifo depth must be a power of two");
  end

  assign count     = wr_q - rd_q;
  assign in_ready  = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
    end
  end
endmodule // sspc_fifo

module sspc_core #(
  parameter int RXTO_CYC = `SSPC_RXTO_CYC,
  parameter int FIFO_D   = `SSPC_FIFO_D
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  // register port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  // serial pins
  input  wire logic        SERIAL_CLOCK_PIN_I,
  output logic             SERIAL_CLOCK_PIN_O,
  output logic             SERIAL_CLOCK_PIN_OE,
  input  wire logic        FRAME_SELECT_PIN_I,
  output logic             FRAME_SELECT_PIN_O,
  output logic             FRAME_SELECT_PIN_OE,
  output logic             SERIAL_OUT_PIN_O,
  output logic             SERIAL_OUT_PIN_OE,
  input  wire logic        SERIAL_IN_PIN_I,
  // cause and dma request levels
  output logic [3:0]       IRQ_CAUSE_O,
  output logic             DMA_TX_REQ_O,
  output logic             DMA_RX_REQ_O
);
  localparam int FW = `SSPC_FIFO_W;

  if (RXTO_CYC < 2 || RXTO_CYC > 65535 || FIFO_D < 2) begin : g_chk
    $error("sspc_core parameter out of range");
  end

  sspc_pkg::sspc_cr0_s   cr0_q;      // control_zero
  logic [3:0]            cr1_q;      // control_one
  logic [7:0]            cpsr_q;     // clock_prescale
  logic [3:0]            imsc_q;     // irq_mask_set
  logic [1:0]            dma_q;      // dma_control
  logic                  ror_q;      // sticky overrun
  logic                  rt_q;       // sticky timeout
  logic [15:0]           to_q;       // rx idle counter
  logic [31:0]           rdata_q;    // read answer
  logic [3:0]            irq_q;      // masked causes out
  logic                  dtx_q;      // dma tx request
  logic                  drx_q;      // dma rx request
  sspc_pkg::sspc_state_e state_q;    // engine state
  sspc_pkg::sspc_state_e state_d;
  sspc_pkg::sspc_pins_s  pins_q;     // registered pin drive
  logic [15:0]           half_q;     // half period counter
  logic [15:0]           sh_tx_q;    // tx shifter, msb out
  logic [15:0]           sh_rx_q;    // rx shifter, lsb in
  logic [4:0]            bit_q;      // bits done in frame
  logic                  first_q;    // hold first bit out
  logic                  sclk_prev_q; // previous slave clock

  // register decode
  wire wr_dr  = REG_WR && REG_ADDR == `SSPC_OFS_DR;
  wire wr_icr = REG_WR && REG_ADDR == `SSPC_OFS_ICR;
  wire rd_dr  = REG_RD && REG_ADDR == `SSPC_OFS_DR;

  // fifo and buffer handshakes
  logic          tx_rdy, tx_vld, buf_rdy, buf_vld, rx_rdy, rx_vld;
  logic [FW-1:0] tx_dat, buf_dat, rx_dat, rx_word;
  logic [3:0]    tx_cnt, rx_cnt;
  logic          load, rx_push;

  sspc_fifo #(.W(FW), .D(FIFO_D), .AW(3)) u_txf (
    .clk(CORE_CLK), .arst_n(ARST_N),
    .in_valid(wr_dr), .in_ready(tx_rdy), .in_data(REG_WDATA[FW-1:0]),
    .out_valid(tx_vld), .out_ready(buf_rdy), .out_data(tx_dat), .count(tx_cnt));

  // two-entry stage ahead of the shifter; it stalls the tx fifo
  sspc_fifo #(.W(FW), .D(`SSPC_BUF_D), .AW(1)) u_buf (
    .clk(CORE_CLK), .arst_n(ARST_N),
    .in_valid(tx_vld), .in_ready(buf_rdy), .in_data(tx_dat),
    .out_valid(buf_vld), .out_ready(load), .out_data(buf_dat), .count());

  sspc_fifo #(.W(FW), .D(FIFO_D), .AW(3)) u_rxf (
    .clk(CORE_CLK), .arst_n(ARST_N),
    .in_valid(rx_push), .in_ready(rx_rdy), .in_data(rx_word),
    .out_valid(rx_vld), .out_ready(rd_dr), .out_data(rx_dat), .count(rx_cnt));

  // mode decode
  wire en      = cr1_q[`SSPC_CR1_EN];
  wire slave   = cr1_q[`SSPC_CR1_SLV];
  wire loop_on = cr1_q[`SSPC_CR1_LOOP];
  wire is_spi  = cr0_q.fmt == sspc_pkg::FMT_SPI;
  wire is_sync = cr0_q.fmt == sspc_pkg::FMT_SYNC;
  wire is_mw   = cr0_q.fmt == sspc_pkg::FMT_MW;
  wire pol = is_spi && cr0_q.polarity;
  wire pha = is_sync || (is_spi && cr0_q.phase);
  wire [4:0] nbits = 5'(cr0_q.size) + 5'd1;
  wire [4:0] total = is_mw ? nbits + `SSPC_MW_CMD : nbits;
  wire [3:0] gap   = 4'hF - cr0_q.size;
  wire din = loop_on ? sh_tx_q[15] : SERIAL_IN_PIN_I;
  // a half period is prescale/2 * (1+rate), so a full bit is prescale*(1+rate)
  wire [15:0] half_len = 16'(cpsr_q[7:1]) * (16'(cr0_q.rate) + 16'd1);

  // edge events; slave pins are sampled directly, so the far clock
  // must stay well below the core clock
  wire tick    = !slave && state_q != sspc_pkg::ST_IDLE && half_q == 16'h0000;
  wire m_lead  = tick && pins_q.sclk == pol;
  wire m_trail = tick && pins_q.sclk != pol;
  wire s_lead  = sclk_prev_q == pol && SERIAL_CLOCK_PIN_I != pol;
  wire s_trail = sclk_prev_q != pol && SERIAL_CLOCK_PIN_I == pol;
  wire lead    = slave ? s_lead : m_lead;
  wire trail   = slave ? s_trail : m_trail;
  wire shift_e = pha ? lead : trail;
  wire samp_e  = pha ? trail : lead;
  wire xfer    = state_q == sspc_pkg::ST_XFER;

  // frame start: master needs a word, slave follows the frame pin
  wire s_start = is_sync ? (FRAME_SELECT_PIN_I && trail) : !FRAME_SELECT_PIN_I;
  wire start = en && state_q == sspc_pkg::ST_IDLE && (slave ? s_start : buf_vld);
  wire done  = xfer && trail && bit_q == total - 5'd1;
  wire abort = xfer && slave && !is_sync && FRAME_SELECT_PIN_I;
  assign load = start && buf_vld;

  // received word, last sample folded in when it falls on this edge
  wire [15:0] rx_raw = pha ? {sh_rx_q[14:0], din} : sh_rx_q;
  assign rx_word = rx_raw & (16'hFFFF >> gap);
  assign rx_push = done;

  // next engine state
  always_comb begin
    state_d = state_q;
    case (state_q)
      sspc_pkg::ST_IDLE: if (start) begin
        state_d = (!slave && is_sync) ? sspc_pkg::ST_LEAD : sspc_pkg::ST_XFER;
      end
      sspc_pkg::ST_LEAD: if (trail) state_d = sspc_pkg::ST_XFER;
      sspc_pkg::ST_XFER: if (done || abort) state_d = sspc_pkg::ST_IDLE;
      default: state_d = sspc_pkg::ST_IDLE;
    endcase
    if (!en) state_d = sspc_pkg::ST_IDLE;
  end

  // engine state register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) state_q <= sspc_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  // half period divider, reloaded while idle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) half_q <= 16'h0000;
    else if (state_q == sspc_pkg::ST_IDLE || half_q == 16'h0000) half_q <= half_len - 16'd1;
    else half_q <= half_q - 16'd1;
  end

  // shifters and bit count
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sh_tx_q <= 16'h0000;
      sh_rx_q <= 16'h0000;
      bit_q   <= 5'd0;
      first_q <= 1'b0;
    end else if (start) begin
      // slave with nothing queued sends zeros
      sh_tx_q <= !buf_vld ? 16'h0000 : is_mw ? {buf_dat[7:0], 8'h00} : buf_dat << gap;
      sh_rx_q <= 16'h0000;
      bit_q   <= 5'd0;
      first_q <= pha;
    end else if (xfer) begin
      if (shift_e) begin
        if (first_q) first_q <= 1'b0;
        else sh_tx_q <= {sh_tx_q[14:0], 1'b0};
      end
      if (samp_e) sh_rx_q <= {sh_rx_q[14:0], din};
      if (trail) bit_q <= bit_q + 5'd1;
    end
  end

  // pin drive, all registered
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pins_q      <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= SERIAL_CLOCK_PIN_I;
      if (slave || state_d == sspc_pkg::ST_IDLE) pins_q.sclk <= pol;
      else if (tick) pins_q.sclk <= !pins_q.sclk;
      pins_q.sclk_oe <= en && !slave;
      pins_q.fss_oe  <= en && !slave;
      // sync format: one-bit high pulse ahead of data; others: low for the frame
      pins_q.fss <= is_sync ? state_d == sspc_pkg::ST_LEAD : state_d != sspc_pkg::ST_XFER;
      pins_q.sdo_oe <= en && !(slave && cr1_q[`SSPC_CR1_OUTDIS]);
    end
  end

  assign SERIAL_CLOCK_PIN_O  = pins_q.sclk;
  assign SERIAL_CLOCK_PIN_OE = pins_q.sclk_oe;
  assign FRAME_SELECT_PIN_O  = pins_q.fss;
  assign FRAME_SELECT_PIN_OE = pins_q.fss_oe;
  assign SERIAL_OUT_PIN_O    = sh_tx_q[15];
  assign SERIAL_OUT_PIN_OE   = pins_q.sdo_oe;

  // control registers; upper bits are dropped on write
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cr0_q  <= `SSPC_CR0_RST;
      cr1_q  <= `SSPC_CR1_RST;
      cpsr_q <= `SSPC_CPSR_RST;
      imsc_q <= `SSPC_IMSC_RST;
      dma_q  <= `SSPC_DMA_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `SSPC_OFS_CR0:  cr0_q  <= REG_WDATA[15:0];
        `SSPC_OFS_CR1:  cr1_q  <= REG_WDATA[3:0];
        `SSPC_OFS_CPSR: cpsr_q <= {REG_WDATA[7:1], 1'b0}; // odd divisors cannot be held
        `SSPC_OFS_IMSC: imsc_q <= REG_WDATA[3:0];
        `SSPC_OFS_DMA:  dma_q  <= REG_WDATA[1:0];
        default: ;
      endcase
    end
  end

  // interrupt causes
  wire ror_set = rx_push && !rx_rdy;  // word dropped, fifo full
  wire rt_set  = rx_vld && !rd_dr && !rx_push && to_q == 16'(RXTO_CYC - 1);
  wire [3:0] raw = {tx_cnt <= 4'(`SSPC_REQ_LVL), rx_cnt >= 4'(`SSPC_REQ_LVL), rt_q, ror_q};
  wire [3:0] mis = raw & imsc_q;

  // sticky causes; a set in the clearing cycle wins
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ror_q <= 1'b0;
      rt_q  <= 1'b0;
      to_q  <= 16'h0000;
    end else begin
      if (ror_set) ror_q <= 1'b1;
      else if (wr_icr && REG_WDATA[`SSPC_INT_ROR]) ror_q <= 1'b0;
      if (rt_set) rt_q <= 1'b1;
      else if (wr_icr && REG_WDATA[`SSPC_INT_RT]) rt_q <= 1'b0;
      // timeout counts idle cycles while words wait unread
      if (!rx_vld || rd_dr || rx_push) to_q <= 16'h0000;
      else if (to_q != 16'(RXTO_CYC)) to_q <= to_q + 16'd1;
    end
  end

  // read answer, valid only the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) rdata_q <= 32'h0000_0000;
    else if (!REG_RD) rdata_q <= 32'h0000_0000;
    else begin
      case (REG_ADDR)
        `SSPC_OFS_CR0:  rdata_q <= {16'h0000, cr0_q};
        `SSPC_OFS_CR1:  rdata_q <= {28'h0, cr1_q};
        `SSPC_OFS_DR:   rdata_q <= rx_vld ? {16'h0000, rx_dat} : 32'h0;
        `SSPC_OFS_SR:   rdata_q <= {27'h0, state_q != sspc_pkg::ST_IDLE || tx_vld || buf_vld,
                                    !rx_rdy, rx_vld, tx_rdy, tx_cnt == 4'h0};
        `SSPC_OFS_CPSR: rdata_q <= {24'h0, cpsr_q};
        `SSPC_OFS_IMSC: rdata_q <= {28'h0, imsc_q};
        `SSPC_OFS_RIS:  rdata_q <= {28'h0, raw};
        `SSPC_OFS_MIS:  rdata_q <= {28'h0, mis};
        `SSPC_OFS_DMA:  rdata_q <= {30'h0, dma_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // cause and dma request outputs
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_q <= 4'h0;
      dtx_q <= 1'b0;
      drx_q <= 1'b0;
    end else begin
      irq_q <= mis;
      dtx_q <= dma_q[`SSPC_DMA_TX] && tx_rdy;
      drx_q <= dma_q[`SSPC_DMA_RX] && rx_vld;
    end
  end

  assign REG_RDATA    = rdata_q;
  assign IRQ_CAUSE_O  = irq_q;
  assign DMA_TX_REQ_O = dtx_q;
  assign DMA_RX_REQ_O = drx_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  tx_full_hold_a: assert property ((wr_dr && !tx_rdy && !(tx_vld && buf_rdy)) |=> tx_cnt == $past(tx_cnt))
    else $error("tx fifo took a word while full");
  ror_sets_a: assert property (ror_set |=> ror_q && raw[`SSPC_INT_ROR])
    else $error("overrun not flagged");
  half_reload_a: assert property (tick |=> half_q == $past(half_len) - 16'd1)
    else $error("divider reload wrong");
  sclk_on_tick_a: assert property ((xfer && $past(xfer) && !slave && $changed(pins_q.sclk)) |-> $past(tick))
    else $error("master clock moved without a tick");
  dr_pop_a: assert property ((rd_dr && rx_vld && !rx_push) |=> rx_cnt == $past(rx_cnt) - 4'd1)
    else $error("data read did not pop");
  mis_read_a: assert property ((REG_RD && REG_ADDR == `SSPC_OFS_MIS) |=> REG_RDATA == {28'h0, $past(raw & imsc_q)})
    else $error("masked status wrong");
  loop_sample_a: assert property ((loop_on && xfer && samp_e && !start) |=> sh_rx_q[0] == $past(sh_tx_q[15]))
    else $error("loopback sample wrong");
  first_hold_a: assert property ((xfer && pha && shift_e && first_q) |=> sh_tx_q == $past(sh_tx_q))
    else $error("first bit shifted early");
  idle_level_a: assert property ((state_q == sspc_pkg::ST_IDLE)[*2] |-> pins_q.sclk == $past(pol))
    else $error("clock idle level wrong");
  ssi_pulse_a: assert property ((state_q == sspc_pkg::ST_LEAD && $stable(cr0_q)) |-> pins_q.fss)
    else $error("ssi frame pulse missing");
  word_len_a: assert property ((done && !is_mw) |-> bit_q == 5'(cr0_q.size))
    else $error("word length wrong");
  sod_off_a: assert property ((en && slave && cr1_q[`SSPC_CR1_OUTDIS]) |=> !SERIAL_OUT_PIN_OE)
    else $error("slave output not disabled");
  disable_a: assert property (!en |=> state_q == sspc_pkg::ST_IDLE)
    else $error("engine runs while disabled");
  rsvd_zero_a: assert property ((REG_RD && REG_ADDR == `SSPC_OFS_CR0) |=> REG_RDATA[31:16] == 16'h0000)
    else $error("reserved control bits not zero");

  master_word_c: cover property (!slave && done);
  slave_word_c:  cover property (slave && done);
  overrun_c:     cover property (ror_set);
  loop_word_c:   cover property (loop_on && done);
endmodule // sspc_core
`default_nettype wire

// ==== sspc_core_bench.sv ====
`timescale 1ns/1ps
`include "sspc_params.svh"
`default_nettype none
// self-checking bench for the serial port core
module sspc_core_bench;
  // clock, reset and register port
  logic        CORE_CLK, ARST_N, REG_WR, REG_RD;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  // pin outputs and the bench's own pin drive
  logic        sck_o, sck_oe, fs_o, fs_oe, so_o, so_oe, si;
  logic        sck_tb, fs_tb, dma_tx, dma_rx, sck_prev;
  logic [3:0]  cause;
  // peer set-up and results
  logic        pol, pha;
  logic [4:0]  nb;
  logic [15:0] reply, got;
  logic [15:0] words [9];
  int          n_mismatch, cmp_count, half, cyc, edges;
  // wire levels: whoever enables drives, else the bench level
  wire logic   sck_w = sck_oe ? sck_o : sck_tb;
  wire logic   fs_w  = fs_oe ? fs_o : fs_tb;
  // frame as the peer sees it: it ends at the very edge of the last clock
  // change, so a short lag keeps that last edge inside the frame
  wire logic   fs_pr;
  assign #1 fs_pr = fs_w;

  // short timeout so the timeout cause shows quickly
  sspc_core #(.RXTO_CYC(8)) dut (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SERIAL_CLOCK_PIN_I(sck_w), .SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE(sck_oe),
    .FRAME_SELECT_PIN_I(fs_w), .FRAME_SELECT_PIN_O(fs_o), .FRAME_SELECT_PIN_OE(fs_oe),
    .SERIAL_OUT_PIN_O(so_o), .SERIAL_OUT_PIN_OE(so_oe), .SERIAL_IN_PIN_I(si),
    .IRQ_CAUSE_O(cause), .DMA_TX_REQ_O(dma_tx), .DMA_RX_REQ_O(dma_rx));
  sspc_peer peer (.sclk(sck_w), .fss_n(fs_pr), .sdo(so_o), .sdi(si), .pol(pol), .pha(pha),
    .nbits(nb), .reply(reply), .got(got));

  // clock
  initial begin
    CORE_CLK = 1'h0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  // half period in core cycles, taken at each serial clock change
  always @(posedge CORE_CLK) begin
    if (sck_o !== sck_prev) begin
      half = cyc;
      cyc  = 1;
    end else begin
      cyc++;
    end
    sck_prev = sck_o;
  end
  // rising serial clock edges inside a frame
  always @(posedge sck_w) if (!fs_pr) edges++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] msk(input int n);
    return 16'hFFFF >> (16 - n);
  endfunction
  // word-wide accesses only
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge CORE_CLK);
    {REG_WR, REG_ADDR, REG_WDATA} <= {1'h1, a, v};
    @(posedge CORE_CLK);
    REG_WR <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge CORE_CLK);
    {REG_RD, REG_ADDR} <= {1'h1, a};
    @(posedge CORE_CLK);
    REG_RD <= 1'h0;
    #1 v = REG_RDATA;
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask
  // bounded wait for empty transmit side and idle engine
  task automatic idle_wait();
    logic [31:0] s;
    repeat (4) @(posedge CORE_CLK);
    for (int i = 0; i < 400; i++) begin
      rd(`SSPC_OFS_SR, s);
      if (s[`SSPC_SR_BSY] === 1'h0 && s[`SSPC_SR_TFE] === 1'h1) return;
    end
    check("idle wait", 32'h1, 32'h0);
    summarize();
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // main sequence; the reserved address range is never touched
  initial begin
    {ARST_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    {sck_tb, fs_tb, pol, pha, nb, reply} = {2'h1, 2'h0, 5'h10, 16'h0000};
    {n_mismatch, cmp_count, half, cyc, edges, sck_prev} = '0;
    void'($urandom(84297));
    repeat (12) @(posedge CORE_CLK);
    ARST_N <= 1'h1;
    // reset values and reserved bits
    rchk("control_zero", `SSPC_OFS_CR0, 32'h0);
    rchk("control_one", `SSPC_OFS_CR1, 32'h0);
    rchk("clock_prescale", `SSPC_OFS_CPSR, 32'h2);
    rchk("port_status", `SSPC_OFS_SR, 32'h3);
    rchk("irq_raw_status", `SSPC_OFS_RIS, 32'h8);
    rchk("irq_masked_status", `SSPC_OFS_MIS, 32'h0);
    wr(`SSPC_OFS_CR0, 32'hFFFFFFFF);
    rchk("reserved bits", `SSPC_OFS_CR0, 32'h0000FFFF);
    wr(`SSPC_OFS_CPSR, 32'h7);
    rchk("odd prescale", `SSPC_OFS_CPSR, 32'h6);
    $display("test reset done");
    // loopback: fill the receive side, then overflow it
    wr(`SSPC_OFS_CPSR, 32'h2);
    wr(`SSPC_OFS_CR0, 32'hF);
    wr(`SSPC_OFS_CR1, 32'h3);
    for (int i = 0; i < 9; i++) begin
      words[i] = 16'($urandom);
      wr(`SSPC_OFS_DR, {16'h0, words[i]});
      if (i == 7) idle_wait();
      if (i == 7) rchk("rx full", `SSPC_OFS_SR, 32'hF);
    end
    idle_wait();
    repeat (12) @(posedge CORE_CLK);
    rchk("all causes raw", `SSPC_OFS_RIS, 32'hF);
    rchk("masked none", `SSPC_OFS_MIS, 32'h0);
    wr(`SSPC_OFS_IMSC, 32'h5);
    rchk("masked", `SSPC_OFS_MIS, 32'h5);
    check("cause pins", {28'h0, cause}, 32'h5);
    wr(`SSPC_OFS_DMA, 32'h3);
    repeat (2) @(posedge CORE_CLK);
    #1 check("dma requests", {30'h0, dma_tx, dma_rx}, 32'h3);
    wr(`SSPC_OFS_DMA, 32'h0);
    wr(`SSPC_OFS_ICR, 32'h1);
    rd(`SSPC_OFS_RIS, d);
    check("overrun cleared", {31'h0, d[0]}, 32'h0);
    for (int i = 0; i < 8; i++) rchk("loop word", `SSPC_OFS_DR, {16'h0, words[i]});
    rchk("empty read", `SSPC_OFS_DR, 32'h0);
    rchk("drained", `SSPC_OFS_SR, 32'h3);
    check("cause pins low", {28'h0, cause}, 32'h0);
    wr(`SSPC_OFS_IMSC, 32'h0);
    $display("test loopback done");
    // all four clock modes against the peer, 4-bit and 16-bit words among them
    wr(`SSPC_OFS_CR1, 32'h2);
    for (int m = 0; m < 4; m++) begin
      logic [3:0]  sz;
      logic [15:0] tx;
      sz = (m == 0) ? 4'h3 : (m == 1) ? 4'hF : 4'($urandom_range(14, 4));
      {pha, pol} = 2'(m);
      nb = {1'h0, sz} + 5'h1;
      reply = 16'($urandom);
      tx = 16'($urandom);
      wr(`SSPC_OFS_CPSR, (m == 3) ? 32'h4 : 32'h2);
      wr(`SSPC_OFS_CR0, {16'h0, (m == 3) ? 8'h02 : 8'h00, pha, pol, 2'h0, sz});
      repeat (3) @(posedge CORE_CLK);
      check("idle clock", {31'h0, sck_o}, {31'h0, pol});
      edges = 0;
      wr(`SSPC_OFS_DR, {16'h0, tx});
      idle_wait();
      check("peer word", {16'h0, got & msk(nb)}, {16'h0, tx & msk(nb)});
      rchk("reply word", `SSPC_OFS_DR, {16'h0, reply & msk(nb)});
      check("bit count", 32'(edges), 32'(nb));
      check("half period", 32'(half), (m == 3) ? 32'h6 : 32'h1);
    end
    $display("test modes done");
    // sync-serial round trip, then half-duplex frame length
    wr(`SSPC_OFS_CPSR, 32'h2);
    wr(`SSPC_OFS_CR0, 32'h17);
    wr(`SSPC_OFS_CR1, 32'h3);
    wr(`SSPC_OFS_DR, 32'hA5);
    idle_wait();
    rchk("sync word", `SSPC_OFS_DR, 32'hA5);
    wr(`SSPC_OFS_CR0, 32'h27);
    wr(`SSPC_OFS_CR1, 32'h2);
    edges = 0;
    wr(`SSPC_OFS_DR, 32'h5A);
    idle_wait();
    check("command and reply", 32'(edges), 32'h10);
    rd(`SSPC_OFS_DR, d);
    $display("test formats done");
    // slave: bench clocks at one twelfth of the core clock
    wr(`SSPC_OFS_CR0, 32'h7);
    wr(`SSPC_OFS_CPSR, 32'h2);
    wr(`SSPC_OFS_CR1, 32'h6);
    {pol, pha, nb, reply} = {2'h0, 5'h8, 16'($urandom)};
    sck_tb <= 1'h0;
    repeat (2) @(posedge CORE_CLK);
    #1 check("slave drive", {29'h0, sck_oe, fs_oe, so_oe}, 32'h1);
    @(posedge CORE_CLK) fs_tb <= 1'h0;
    repeat (6) @(posedge CORE_CLK);
    repeat (16) begin
      sck_tb <= ~sck_tb;
      repeat (6) @(posedge CORE_CLK);
    end
    fs_tb <= 1'h1;
    repeat (6) @(posedge CORE_CLK);
    rchk("slave word", `SSPC_OFS_DR, {24'h0, reply[7:0]});
    wr(`SSPC_OFS_CR1, 32'hE);
    repeat (2) @(posedge CORE_CLK);
    #1 check("output disabled", {29'h0, sck_oe, fs_oe, so_oe}, 32'h0);
    $display("test slave done");
    // fill while disabled, then reset in mid-run
    wr(`SSPC_OFS_CR1, 32'h0);
    for (int i = 0; i < 11; i++) wr(`SSPC_OFS_DR, 32'(i));
    rd(`SSPC_OFS_SR, d);
    check("tx full", {31'h0, d[`SSPC_SR_TNF]}, 32'h0);
    ARST_N <= 1'h0;
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'h1;
    rchk("status after reset", `SSPC_OFS_SR, 32'h3);
    rchk("control_zero after reset", `SSPC_OFS_CR0, 32'h0);
    $display("test reset again done");
    summarize();
  end
endmodule // sspc_core_bench
`default_nettype wire

// ==== sspc_params.svh ====
`ifndef SSPC_PARAMS_SVH
`define SSPC_PARAMS_SVH
// register offsets, byte addresses
`define SSPC_OFS_CR0  12'h000
`define SSPC_OFS_CR1  12'h004
`define SSPC_OFS_DR   12'h008
`define SSPC_OFS_SR   12'h00C
`define SSPC_OFS_CPSR 12'h010
`define SSPC_OFS_IMSC 12'h014
`define SSPC_OFS_RIS  12'h018
`define SSPC_OFS_MIS  12'h01C
`define SSPC_OFS_ICR  12'h020
`define SSPC_OFS_DMA  12'h024
// control_one bit positions
`define SSPC_CR1_LOOP   0
`define SSPC_CR1_EN     1
`define SSPC_CR1_SLV    2
`define SSPC_CR1_OUTDIS 3
// port_status bit positions
`define SSPC_SR_TFE 0
`define SSPC_SR_TNF 1
`define SSPC_SR_RNE 2
`define SSPC_SR_RFF 3
`define SSPC_SR_BSY 4
// interrupt cause bit positions
`define SSPC_INT_ROR 0
`define SSPC_INT_RT  1
`define SSPC_INT_RX  2
`define SSPC_INT_TX  3
// dma_control bit positions
`define SSPC_DMA_RX 0
`define SSPC_DMA_TX 1
// reset values
`define SSPC_CR0_RST  16'h0000
`define SSPC_CR1_RST  4'h0
`define SSPC_CPSR_RST 8'h02
`define SSPC_IMSC_RST 4'h0
`define SSPC_DMA_RST  2'h0
// sizes and levels
`define SSPC_FIFO_W    16
`define SSPC_FIFO_D    8
`define SSPC_BUF_D     2
`define SSPC_REQ_LVL   4
`define SSPC_MW_CMD    5'd8
`define SSPC_RXTO_CYC  1024
`endif

// ==== sspc_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side spi peer: shifts a reply out, records what arrives
module sspc_peer (
  // serial wires
  input  wire logic        sclk,
  input  wire logic        fss_n,
  input  wire logic        sdo,
  output logic             sdi,
  // mode and data
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] reply,
  output logic [15:0]      got
);
  int k;  // bits presented so far
  initial begin
    sdi = 1'h0;
    got = 16'h0000;
    k   = 0;
  end
  // next reply bit, msb first; past the word the line wanders
  task automatic show();
    sdi = (k < nbits) ? reply[nbits - 1 - k] : ~sdi;
    k++;
  endtask
  // frame start; phase 0 needs its first bit before any edge
  always @(negedge fss_n) begin
    k   = 0;
    got = 16'h0000;
    if (!pha) show();
  end
  // a released line must not keep its last value
  always @(posedge fss_n) sdi = ~sdi;
  // leaving the idle level is the leading edge
  always @(sclk) begin
    if (!fss_n && ((sclk !== pol) != pha)) got = {got[14:0], sdo};
    else if (!fss_n) show();
  end
endmodule // sspc_peer
`default_nettype wire

// ==== sspc_pkg.sv ====
package sspc_pkg;
  // frame format field codes
  typedef enum logic [1:0] {
    FMT_SPI = 2'h0,
    FMT_SYNC = 2'h1,
    FMT_MW  = 2'h2,
    FMT_RSV = 2'h3
  } sspc_fmt_e;
  // control_zero layout
  typedef struct packed {
    logic [7:0] rate;
    logic       phase;
    logic       polarity;
    sspc_fmt_e  fmt;
    logic [3:0] size;
  } sspc_cr0_s;
  // serial engine states
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_XFER} sspc_state_e;
  // pin drive bundle
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic fss;
    logic fss_oe;
    logic sdo_oe;
  } sspc_pins_s;
endpackage
